// ===== bench/lu_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lu_chk
  import lu_pkg::*;
#(
  parameter logic [2:0] REVISION = 3'h1  // arbitrary value
) (
  // clock, reset and bus
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  // pins
  input wire logic        impedance_variant_bit_i,
  input wire logic [7:0]  signal_loss_raw_i,
  input wire logic [7:0]  driver_fault_raw_i,
  input wire lu_pair_s    line_tx_o,
  input wire lu_rail_s    sys_rx_o,
  input wire logic        irq_o
);
  // ****************************************************************
  // helpers: strap copy, detector stability counts
  // ****************************************************************
  logic       imp_q;
  logic [7:0] los_p;
  logic [7:0] df_p;
  logic [3:0] los_n;
  logic [3:0] df_n;

  // counts saturate so a long quiet pin never wraps back to zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) imp_q <= impedance_variant_bit_i;
    los_p <= signal_loss_raw_i;
    df_p  <= driver_fault_raw_i;
    los_n <= (rst_i || los_p != signal_loss_raw_i) ? 4'h0 : los_n + {3'h0, los_n != 4'hF};
    df_n  <= (rst_i || df_p != driver_fault_raw_i) ? 4'h0 : df_n + {3'h0, df_n != 4'hF};
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // read taken, then one at a given address
  sequence s_any_rd;
    hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  endsequence
  sequence s_rd(logic [31:0] a);
    s_any_rd ##0 haddr_i == a;
  endsequence

  a_id_imp: assert property (s_rd(32'h0) |=> hrdata_o[7] == imp_q)
    else $error("identity variant bit wrong");
  a_id_ports: assert property (s_rd(32'h0) |=> hrdata_o[6:3] == 4'h8)
    else $error("identity channel count wrong");
  a_id_rev: assert property (s_rd(32'h0) |=> hrdata_o[2:0] == REVISION)
    else $error("identity revision wrong");
  a_los_status: assert property (s_rd(32'h10) ##0 los_n > 4'h8 |=> hrdata_o[7:0] == $past(signal_loss_raw_i))
    else $error("loss status does not follow detector");
  a_df_status: assert property (s_rd(32'h14) ##0 df_n > 4'h8 |=> hrdata_o[7:0] == $past(driver_fault_raw_i))
    else $error("fault status does not follow detector");
  a_upper_zero: assert property (s_any_rd |=> hrdata_o[31:8] == 24'h0)
    else $error("read data above the channel byte");
  a_unaligned_zero: assert property (s_any_rd ##0 haddr_i[1:0] != 2'h0 |=> hrdata_o == 32'h0)
    else $error("unaligned read returned data");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !irq_o && line_tx_o == '0 && sys_rx_o == '0)
    else $error("outputs active after reset");
endmodule : lu_chk
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lu_pkg::*;
  typedef struct packed {
    logic [31:0] a;
    logic [7:0]  w;
    logic [7:0]  e;
  } lu_row_s;
  localparam logic [2:0] REV = 3'h1;  // arbitrary value
  logic        clk, rst, sel, hw, tick, imp, rdy, resp, irq;
  logic [1:0]  trn;
  logic [7:0]  los, df, t0;
  logic [31:0] adr, wd, rdat;
  lu_pair_s    rx, ltx;
  lu_rail_s    stx, srx;
  int          error_cnt, checks_done;
  // writable registers first, then identity, status and unmapped places
  lu_row_s     rows [11] = '{'{32'h04, 8'hA5, 8'hA5}, '{32'h08, 8'h5A, 8'h5A},
    '{32'h0C, 8'h0F, 8'h0F}, '{32'h18, 8'h81, 8'h81}, '{32'h1C, 8'h7E, 8'h7E},
    '{32'h30, 8'h3C, 8'h3C}, '{32'h00, 8'hFF, {1'b1, 4'h8, REV}}, '{32'h10, 8'hFF, 8'h00},
    '{32'h14, 8'hFF, 8'h00}, '{32'h400, 8'hFF, 8'h00}, '{32'h02, 8'hFF, 8'h00}};

  lu_regs #(.REVISION(REV)) i_lu_regs (
    .ref_clk_i(clk), .rst_i(rst), .hsel_i(sel), .haddr_i(adr), .htrans_i(trn),
    .hwrite_i(hw), .hsize_i(3'h2), .hready_i(rdy), .hwdata_i(wd), .hrdata_o(rdat),
    .hreadyout_o(rdy), .hresp_o(resp), .impedance_variant_bit_i(imp),
    .signal_loss_raw_i(los), .driver_fault_raw_i(df), .mclk_tick_i(tick),
    .line_rx_i(rx), .line_tx_o(ltx), .sys_tx_i(stx), .sys_rx_o(srx), .irq_o(irq));

  // ****************************************************************
  // clock, bus tasks and checks
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask : chk

  // one single transfer; waits on hready, no cycle count assumed
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge clk);
    sel <= 1'b1;
    trn <= 2'h2;
    adr <= a;
    hw  <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    sel <= 1'b0;
    trn <= 2'h0;
    wd  <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    r = rdat;
  endtask : bus

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    @(posedge clk);  // write lands at the data-phase edge; look after it settles
  endtask : wr

  task automatic rd(input logic [31:0] a, e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
    chk(32'(resp), 32'h0);  // every answer is OKAY
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic finish_test;
    $display("mismatches %0d of %0d checks", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    wt(20000);
    error_cnt++;
    finish_test;
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {sel, hw, tick, trn, adr, wd, los, df, rx, stx, error_cnt, checks_done} = '0;
    rst = 1'b1;
    imp = 1'b1;
    wt(16);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(rows[i].a, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, {24'h0, rows[i].w});
      rd(rows[i].a, {24'h0, rows[i].e});
    end
    for (int i = 0; i < 6; i++) wr(rows[i].a, 32'h0);
    // loss flag, read clear, both toggle directions
    wr(32'h18, 32'h01);
    los <= 8'h01;
    wt(12);
    rd(32'h10, 32'h01);
    chk(32'(irq), 32'h1);
    rd(32'h20, 32'h01);
    rd(32'h20, 32'h00);
    los <= 8'h00;
    wt(12);
    chk(32'(irq), 32'h1);
    wr(32'h18, 32'h00);
    chk(32'(irq), 32'h0);
    rd(32'h20, 32'h01);
    // fault flag with write-one clear; reads leave it
    wr(32'h78, 32'h01);
    df <= 8'h80;
    wt(12);
    rd(32'h14, 32'h80);
    chk(32'(irq), 32'h0);
    rd(32'h24, 32'h80);
    rd(32'h24, 32'h80);
    wr(32'h1C, 32'h80);
    chk(32'(irq), 32'h1);
    wr(32'h24, 32'h80);
    rd(32'h24, 32'h00);
    chk(32'(irq), 32'h0);
    // all ones: rails ignored, polarity moves only with the master tick
    wr(32'h0C, 32'hFF);
    wt(8);
    t0 = ltx.tip;
    repeat (4) begin
      @(posedge clk);
      stx <= ~stx;
      chk(32'(ltx.tip ^ ltx.ring), 32'hFF);
      chk(32'(ltx.tip), 32'(t0));
    end
    tick <= 1'b1;
    wt(8);
    chk(32'(ltx.tip), {24'h0, ~t0});
    wr(32'h0C, 32'h00);
    // dual loopback: line in goes back out, rails go to system side
    wr(32'h08, 32'hFF);
    wr(32'h30, 32'hFF);
    rx  <= '{tip: 8'h96, ring: 8'h41};
    stx <= '{pos: 8'h3C, neg: 8'h05};
    wt(12);
    chk(32'(ltx), 32'(rx));
    chk(32'(srx), 32'(stx));
    wr(32'h30, 32'h00);
    wt(12);
    chk(32'(ltx), 32'(rx));
    // analog loopback: transmit pair returns, receive pair ignored
    wr(32'h08, 32'h00);
    wr(32'h04, 32'hFF);
    stx <= '{pos: 8'hA0, neg: 8'h0A};
    los <= 8'h02;
    wt(12);
    chk(32'(srx), 32'(stx));
    chk(32'(ltx), 32'(stx));
    rd(32'h10, 32'h02);
    // jitter attenuator on both sides adds one stage each way in analog loopback
    wr(32'h78, 32'h07);
    rd(32'h78, 32'h07);
    stx <= '{pos: 8'h5A, neg: 8'h81};
    wt(3);
    chk(32'(srx), 32'h0000A00A);
    wt(4);
    chk(32'(srx), 32'h00005A81);
    // reset in mid-run: controls back to zero, strap caught again
    rst <= 1'b1;
    imp <= 1'b0;
    wt(2);
    rst <= 1'b0;
    imp <= 1'b1;
    rd(32'h04, 32'h0);
    rd(32'h00, {24'h0, 1'b0, 4'h8, REV});
    finish_test;
  end
endmodule : tb_top

bind lu_regs lu_chk #(.REVISION(REVISION)) i_lu_chk (.ref_clk_i, .rst_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .impedance_variant_bit_i,
  .signal_loss_raw_i, .driver_fault_raw_i, .line_tx_o, .sys_rx_o, .irq_o);
`default_nettype wire

// ===== rtl/lu_cfg.svh
`ifndef LU_CFG_SVH
`define LU_CFG_SVH

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define LU_IDX_IDENTITY   8'h00
`define LU_IDX_ALB        8'h01
`define LU_IDX_RLB        8'h02
`define LU_IDX_TAO        8'h03
`define LU_IDX_LOS_ST     8'h04
`define LU_IDX_DF_ST      8'h05
`define LU_IDX_LOS_IE     8'h06
`define LU_IDX_DF_IE      8'h07
`define LU_IDX_LOS_CHG    8'h08
`define LU_IDX_DF_CHG     8'h09
`define LU_IDX_DLB        8'h0C
`define LU_IDX_CONFIG     8'h1E

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define LU_ID_IMP_BIT     7
`define LU_ID_PORT_LSB    3
`define LU_ID_REV_LSB     0
`define LU_PORT_COUNT     4'h8
`define LU_REV_DEFAULT    3'h1
`define LU_CFG_CWS_BIT    0
`define LU_CFG_JATX_BIT   1
`define LU_CFG_JARX_BIT   2
`define LU_CTRL_RESET     8'h00
`define LU_NCH            8
`define LU_NSYNC          33

`endif

// ===== rtl/lu_pkg.sv
package lu_pkg;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] tip;
    logic [7:0] ring;
  } lu_pair_s;

  typedef struct packed {
    logic [7:0] pos;
    logic [7:0] neg;
  } lu_rail_s;

  typedef logic [32:0] lu_sync_t;

  // ****************************************************************
  // whole state of the register bank
  // ****************************************************************
  typedef struct packed {
    lu_sync_t    s1;
    lu_sync_t    s2;
    lu_sync_t    s3;
    lu_sync_t    filt;
    logic [7:0]  alb;
    logic [7:0]  rlb;
    logic [7:0]  dlb;
    logic [7:0]  tao;
    logic [7:0]  los_ie;
    logic [7:0]  df_ie;
    logic [7:0]  los_st;
    logic [7:0]  df_st;
    logic [7:0]  los_chg;
    logic [7:0]  df_chg;
    logic        cws;
    logic        ja_tx;
    logic        ja_rx;
    logic        imp;
    logic        rst_seen;
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_idx;
    logic [31:0] hrdata;
    logic        ones_pol;
    logic        tick_prev;
    lu_rail_s    ja_rx_q;
    lu_rail_s    ja_tx_q;
    lu_pair_s    line_tx;
    lu_rail_s    sys_rx;
  } lu_state_s;

endpackage : lu_pkg

// ===== rtl/lu_regs.sv
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "lu_cfg.svh"

module lu_regs
  import lu_pkg::*;
#(
  parameter logic [2:0] REVISION = `LU_REV_DEFAULT  // arbitrary value
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // straps and detectors (asynchronous pins)
  input  wire logic        impedance_variant_bit_i,
  input  wire logic [7:0]  signal_loss_raw_i,
  input  wire logic [7:0]  driver_fault_raw_i,
  input  wire logic        mclk_tick_i,
  // line side
  input  wire lu_pair_s    line_rx_i,
  output lu_pair_s         line_tx_o,
  // system side
  input  wire lu_rail_s    sys_tx_i,
  output lu_rail_s         sys_rx_o,
  // interrupt request
  output logic             irq_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  lu_state_s q;
  lu_state_s d;

  // read value of one register index; unmapped reads give zero
  function automatic logic [7:0] read_mux(input lu_state_s s, input logic [7:0] idx,
                                          input logic [2:0] rev);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `LU_IDX_IDENTITY: begin
        v[`LU_ID_IMP_BIT]                   = s.imp;
        v[`LU_ID_PORT_LSB +: 4]             = `LU_PORT_COUNT;
        v[`LU_ID_REV_LSB +: 3]              = rev;
      end
      `LU_IDX_ALB:     v = s.alb;
      `LU_IDX_RLB:     v = s.rlb;
      `LU_IDX_TAO:     v = s.tao;
      `LU_IDX_LOS_ST:  v = s.los_st;
      `LU_IDX_DF_ST:   v = s.df_st;
      `LU_IDX_LOS_IE:  v = s.los_ie;
      `LU_IDX_DF_IE:   v = s.df_ie;
      `LU_IDX_LOS_CHG: v = s.los_chg;
      `LU_IDX_DF_CHG:  v = s.df_chg;
      `LU_IDX_DLB:     v = s.dlb;
      `LU_IDX_CONFIG: begin
        v[`LU_CFG_CWS_BIT]  = s.cws;
        v[`LU_CFG_JATX_BIT] = s.ja_tx;
        v[`LU_CFG_JARX_BIT] = s.ja_rx;
      end
      default:         v = 8'h00;
    endcase
    return v;
  endfunction : read_mux

  // true when the byte address lands on an aligned word of the map
  function automatic logic addr_ok(input logic [31:0] a);
    return (a[31:10] == 22'h000000) && (a[1:0] == 2'h0);
  endfunction : addr_ok

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  lu_sync_t   raw;
  logic       take;
  logic       wr_now;
  logic       rd_clear;
  logic [7:0] wbyte;
  logic [7:0] los_new;
  logic [7:0] df_new;
  logic       tick_new;
  lu_rail_s   rx_src;
  lu_rail_s   rx_ja;
  lu_rail_s   tx_ja;
  lu_rail_s   sys_tx;
  logic [7:0] ja_lb;

  // gather asynchronous pins into one vector for the synchroniser
  assign raw = {mclk_tick_i, signal_loss_raw_i, driver_fault_raw_i,
                line_rx_i.tip, line_rx_i.ring};

  always_comb begin
    d = q;

    // three-stage synchroniser; a change counts once stages 2 and 3 agree
    d.s1 = raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < `LU_NSYNC; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.filt[i] = q.s3[i];
      end
    end

    // filtered detector levels, bit k is channel k+1
    tick_new = q.filt[32];
    los_new  = q.filt[31:24];
    df_new   = q.filt[23:16];

    // status follows the detector even in loopback
    d.los_st = los_new;
    d.df_st  = df_new;

    // ahb address phase capture; hreadyout never stalls
    take     = hsel_i && htrans_i[1] && hready_i;
    d.ap_valid = take;
    d.ap_write = hwrite_i;
    d.ap_idx   = addr_ok(haddr_i) ? haddr_i[9:2] : 8'hFF;
    wr_now   = q.ap_valid && q.ap_write;
    wbyte    = hwdata_i[7:0];

    // read data is prepared at the address phase and stands in the data phase
    d.hrdata = 32'h00000000;
    rd_clear = 1'b0;
    if (take && !hwrite_i) begin
      d.hrdata = {24'h000000, read_mux(q, d.ap_idx, REVISION)};
      rd_clear = !q.cws;
    end

    // control writes; identity and status indices fall through untouched
    if (wr_now) begin
      case (q.ap_idx)
        `LU_IDX_ALB:    d.alb    = wbyte;
        `LU_IDX_RLB:    d.rlb    = wbyte;
        `LU_IDX_TAO:    d.tao    = wbyte;
        `LU_IDX_LOS_IE: d.los_ie = wbyte;
        `LU_IDX_DF_IE:  d.df_ie  = wbyte;
        `LU_IDX_DLB:    d.dlb    = wbyte;
        `LU_IDX_CONFIG: begin
          d.cws   = wbyte[`LU_CFG_CWS_BIT];
          d.ja_tx = wbyte[`LU_CFG_JATX_BIT];
          d.ja_rx = wbyte[`LU_CFG_JARX_BIT];
        end
        default: ;
      endcase
    end

    // change flags: clear first, then any toggle sets; the set wins
    if (rd_clear && d.ap_idx == `LU_IDX_LOS_CHG) begin
      d.los_chg = 8'h00;
    end
    if (rd_clear && d.ap_idx == `LU_IDX_DF_CHG) begin
      d.df_chg = 8'h00;
    end
    if (wr_now && q.cws && q.ap_idx == `LU_IDX_LOS_CHG) begin
      d.los_chg = q.los_chg & ~wbyte;
    end
    if (wr_now && q.cws && q.ap_idx == `LU_IDX_DF_CHG) begin
      d.df_chg = q.df_chg & ~wbyte;
    end
    d.los_chg = d.los_chg | (los_new ^ q.los_st);
    d.df_chg  = d.df_chg | (df_new ^ q.df_st);

    // all-ones polarity alternates on each master-clock tick, never on sys clock
    d.tick_prev = tick_new;
    if (tick_new && !q.tick_prev) begin
      d.ones_pol = !q.ones_pol;
    end

    // receive source: analog loopback takes our own transmit pair
    sys_tx = sys_tx_i;
    for (int c = 0; c < `LU_NCH; c++) begin
      rx_src.pos[c] = q.alb[c] ? q.line_tx.tip[c]  : q.filt[8 + c];
      rx_src.neg[c] = q.alb[c] ? q.line_tx.ring[c] : q.filt[c];
    end

    // jitter attenuator modelled as one retiming stage; in analog loopback
    // either side's enable keeps it in the path
    ja_lb     = q.alb & {8{q.ja_tx | q.ja_rx}};
    d.ja_rx_q = rx_src;
    d.ja_tx_q = sys_tx;
    rx_ja.pos = (ja_lb | {8{q.ja_rx}}) & q.ja_rx_q.pos |
                ~(ja_lb | {8{q.ja_rx}}) & rx_src.pos;
    rx_ja.neg = (ja_lb | {8{q.ja_rx}}) & q.ja_rx_q.neg |
                ~(ja_lb | {8{q.ja_rx}}) & rx_src.neg;
    tx_ja     = q.ja_tx ? q.ja_tx_q : sys_tx;

    // line transmit: all-ones beats remote loopback beats system rails
    d.line_tx.tip  = (q.tao & {8{q.ones_pol}}) |
                     (~q.tao & q.rlb & rx_ja.pos) |
                     (~q.tao & ~q.rlb & tx_ja.pos);
    d.line_tx.ring = (q.tao & {8{!q.ones_pol}}) |
                     (~q.tao & q.rlb & rx_ja.neg) |
                     (~q.tao & ~q.rlb & tx_ja.neg);

    // system receive: digital loopback returns the system rails; with remote
    // loopback also set the channel runs both loops at once
    d.sys_rx.pos = (q.dlb & tx_ja.pos) | (~q.dlb & rx_ja.pos);
    d.sys_rx.neg = (q.dlb & tx_ja.neg) | (~q.dlb & rx_ja.neg);

    // synchronous reset; the impedance strap is caught while reset is held
    d.rst_seen = rst_i;
    if (rst_i) begin
      d          = '0;
      d.alb      = `LU_CTRL_RESET;
      d.rlb      = `LU_CTRL_RESET;
      d.dlb      = `LU_CTRL_RESET;
      d.tao      = `LU_CTRL_RESET;
      d.los_ie   = `LU_CTRL_RESET;
      d.df_ie    = `LU_CTRL_RESET;
      d.imp      = impedance_variant_bit_i;
      d.rst_seen = 1'b1;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    q <= d;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // zero-wait slave; every transfer answers OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = q.hrdata;
  assign line_tx_o   = q.line_tx;
  assign sys_rx_o    = q.sys_rx;

  // level request from latched flags gated by per-channel enables
  assign irq_o = |((q.los_chg & q.los_ie) | (q.df_chg & q.df_ie));

endmodule : lu_regs
`default_nettype wire
